// File: hw/mdsd_data_space.v
// Data-space move unit: decodes CPU moves to internal SRAM, lock status,
// reserved space or the multiplexed external bus, and applies the stretch.
// Assumes one 40 MHz clock (one clock stands for one crystal clock, four per
// machine cycle), AXI4-Lite registers and a CPU that waits for moveDone.
`timescale 1ns/100ps
`default_nettype none
`include "mdsd_regs.vh"

module mdsd_data_space #(
   parameter SRAM_DEPTH = 1024
) (
   input  wire        mclk,
   input  wire        rst_n,
   // AXI4-Lite register slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // CPU data-space move port
   input  wire        moveReq,
   input  wire        moveWrite,
   input  wire [15:0] moveAddr,
   input  wire [7:0]  moveWdata,
   output wire        moveReady,
   output reg         moveDone,
   output reg  [7:0]  moveRdata,
   // Lock status pins
   input  wire [2:0]  securityLockFlags,
   // External multiplexed bus
   input  wire [7:0]  p0In,
   output reg  [7:0]  p0Out,
   output reg         p0Oe,
   output reg  [7:0]  p2Out,
   output reg         p2Oe,
   output reg         ale,
   output reg         rdStrobe_n,
   output reg         wrStrobe_n
);

   // Move sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_INT  = 2'h1;
   localparam ST_EXT  = 2'h2;

   // Route of one move under the given map select
   // Select 10 is treated as all external, like the reset setting
   localparam RT_SRAM = 2'h0;
   localparam RT_EXT  = 2'h1;
   localparam RT_LOCK = 2'h2;
   localparam RT_RSVD = 2'h3;

   function [1:0] route;
      input [1:0]  sel;
      input [15:0] addr;
      begin
         if (sel == 2'h1) begin
            route = (addr <= `MDSD_SRAM_LAST) ? RT_SRAM : RT_EXT;
         end else if (sel == 2'h3) begin
            if (addr <= `MDSD_SRAM_LAST)
               route = RT_SRAM;
            else if (addr == `MDSD_LOCK_ADDR)
               route = RT_LOCK;
            else
               route = RT_RSVD;
         end else begin
            route = RT_EXT;
         end
      end
   endfunction

   // Clocks taken by one external move, four per machine cycle; the
   // jump from 5 to 9 machine cycles is where the slow bus timing starts
   function [5:0] ext_clocks;
      input [2:0] s;
      reg   [3:0] mc;
      begin
         case (s)
            3'h0:    mc = 4'h2;
            3'h1:    mc = 4'h3;
            3'h2:    mc = 4'h4;
            3'h3:    mc = 4'h5;
            3'h4:    mc = 4'h9;
            3'h5:    mc = 4'ha;
            3'h6:    mc = 4'hb;
            3'h7:    mc = 4'hc;
            default: mc = 4'h2;
         endcase
         ext_clocks = {mc, 2'b00};
      end
   endfunction

   reg [2:0]  stretch;
   reg [1:0]  mapSel;
   reg [1:0]  state;
   reg [5:0]  tick;
   reg [2:0]  curStretch;
   reg        curWrite;
   reg [15:0] curAddr;
   reg [7:0]  curWdata;
   reg [7:0]  sram [0:SRAM_DEPTH-1];
   reg [2:0]  lockS1;
   reg [2:0]  lockS2;
   reg [2:0]  lockS3;
   reg [2:0]  lockStable;
   reg [7:0]  p0S1;
   reg [7:0]  p0S2;
   reg [7:0]  p0S3;
   reg [7:0]  p0Stable;
   reg        awHeld;
   reg [3:0]  awAddr;
   reg        wHeld;
   reg [31:0] wData;
   reg [3:0]  wStrb;

   // Decode and take in one cycle, from the live map select
   wire [1:0] reqRoute = route(mapSel, moveAddr);
   wire       reqTaken = moveReq && moveReady;
   wire [9:0] sramIdx  = moveAddr[9:0];

   // Ready returns with moveDone, so moves can run back to back
   assign moveReady = (state == ST_IDLE);

   // Phase lengths of an external move, in clocks, from the latched stretch.
   // Order on the pins: address latch, setup, strobe, hold, then idle to the
   // end of the move. Stretch 0 has a half machine cycle strobe and one-clock
   // setup and hold; stretch 1 to 3 add a clock to each; from stretch 4 the
   // latch, setup and hold each gain a machine cycle and stay there, so only
   // the strobe keeps growing with the stretch value.
   reg [5:0] aleLen;
   reg [5:0] setupLen;
   reg [5:0] strobeLen;
   reg [5:0] holdLen;
   reg [5:0] totalLen;
   reg [5:0] strobeBeg;
   reg [5:0] strobeEnd;
   reg       slowMode;
   reg [5:0] readTick;
   reg [7:0] readByte;
   always @* begin
      slowMode  = curStretch[2];
      aleLen    = slowMode ? 6'h06 : 6'h02;
      setupLen  = ((curStretch == 3'h0) ? 6'h01 : 6'h02)
                + (slowMode ? 6'h04 : 6'h00);
      holdLen   = ((curStretch == 3'h0) ? 6'h01 : 6'h02)
                + (slowMode ? 6'h04 : 6'h00);
      strobeLen = (curStretch == 3'h0) ? 6'h02 : {1'b0, curStretch, 2'b00};
      totalLen  = ext_clocks(curStretch);
      strobeBeg = aleLen + setupLen;
      strobeEnd = strobeBeg + strobeLen;
      // Read data waits two clocks past the strobe for the synchroniser;
      // at stretch 0 the move ends first, so its last edge takes stage two
      // and gives up the agreement check: a limit of the fastest setting
      if (curStretch == 3'h0) begin
         readTick = totalLen - 6'h02;
         readByte = p0S2;
      end else begin
         readTick = strobeEnd + 6'h02;
         readByte = p0Stable;
      end
   end

   // Pin inputs: three stages, a value counts once stages two and three agree
   // Costs four clocks of latency; the read sample point allows for it
   always @(posedge mclk) begin
      if (!rst_n) begin
         lockS1     <= 3'h0;
         lockS2     <= 3'h0;
         lockS3     <= 3'h0;
         lockStable <= 3'h0;
         p0S1       <= 8'h00;
         p0S2       <= 8'h00;
         p0S3       <= 8'h00;
         p0Stable   <= 8'h00;
      end else begin
         lockS1 <= securityLockFlags;
         lockS2 <= lockS1;
         lockS3 <= lockS2;
         p0S1   <= p0In;
         p0S2   <= p0S1;
         p0S3   <= p0S2;
         if (lockS2 == lockS3)
            lockStable <= lockS3;
         if (p0S2 == p0S3)
            p0Stable <= p0S3;
      end
   end

   // Move sequencer; stretch and map are sampled once, at acceptance
   always @(posedge mclk) begin
      if (!rst_n) begin
         state      <= ST_IDLE;
         tick       <= 6'h00;
         curStretch <= `MDSD_STRETCH_RESET;
         curWrite   <= 1'b0;
         curAddr    <= 16'h0000;
         curWdata   <= 8'h00;
         moveDone   <= 1'b0;
         moveRdata  <= 8'h00;
      end else begin
         moveDone <= 1'b0;
         case (state)
            ST_IDLE: begin
               tick <= 6'h00;
               // Map and stretch are read in this cycle only
               if (reqTaken) begin
                  curStretch <= stretch;
                  curWrite   <= moveWrite;
                  curAddr    <= moveAddr;
                  curWdata   <= moveWdata;
                  if (reqRoute == RT_EXT) begin
                     state <= ST_EXT;
                  end else begin
                     state <= ST_INT;
                     if (reqRoute == RT_SRAM && !moveWrite)
                        moveRdata <= sram[sramIdx];
                     else if (reqRoute == RT_LOCK && !moveWrite)
                        moveRdata <= {5'h00, lockStable};
                     else if (!moveWrite)
                        moveRdata <= `MDSD_IDLE_DATA;
                  end
               end
            end
            ST_INT: begin
               // Stretch is ignored here: always two machine cycles
               tick <= tick + 6'h01;
               if (tick == `MDSD_INT_CLKS - 6'h02) begin
                  moveDone <= 1'b1;
                  state    <= ST_IDLE;
               end
            end
            ST_EXT: begin
               tick <= tick + 6'h01;
               // Read data taken at the tick worked out with the phases
               if (!curWrite && tick == readTick)
                  moveRdata <= readByte;
               if (tick == totalLen - 6'h02) begin
                  moveDone <= 1'b1;
                  state    <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Internal SRAM write at acceptance; no reset needed for contents
   // A read right after a write therefore sees the new byte
   always @(posedge mclk) begin
      if (reqTaken && moveWrite && reqRoute == RT_SRAM)
         sram[sramIdx] <= moveWdata;
   end

   // External bus pins, registered from the tick of the running move
   always @(posedge mclk) begin
      if (!rst_n) begin
         p0Out      <= 8'h00;
         p0Oe       <= 1'b0;
         p2Out      <= 8'h00;
         p2Oe       <= 1'b0;
         ale        <= 1'b0;
         rdStrobe_n <= 1'b1;
         wrStrobe_n <= 1'b1;
      end else if (state == ST_EXT) begin
         // Pins follow the tick one clock later
         p2Out      <= curAddr[15:8];
         p2Oe       <= 1'b1;
         ale        <= (tick < aleLen);
         rdStrobe_n <= !(!curWrite && tick >= strobeBeg && tick < strobeEnd);
         wrStrobe_n <= !(curWrite && tick >= strobeBeg && tick < strobeEnd);
         if (tick < aleLen + 6'h01) begin
            p0Out <= curAddr[7:0];
            p0Oe  <= 1'b1;
         end else if (curWrite && tick < strobeEnd + holdLen) begin
            p0Out <= curWdata;
            p0Oe  <= 1'b1;
         end else begin
            // Released for reads so the far side can drive it
            p0Oe  <= 1'b0;
         end
      end else begin
         // Bus released between moves; fetches never pass through here
         p0Oe       <= 1'b0;
         p2Oe       <= 1'b0;
         ale        <= 1'b0;
         rdStrobe_n <= 1'b1;
         wrStrobe_n <= 1'b1;
      end
   end

   // AXI write: address and data taken in either order, answer after both
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;

   always @(posedge mclk) begin
      if (!rst_n) begin
         awHeld       <= 1'b0;
         awAddr       <= 4'h0;
         wHeld        <= 1'b0;
         wData        <= 32'h0000_0000;
         wStrb        <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MDSD_RESP_OKAY;
         stretch      <= `MDSD_STRETCH_RESET;
         mapSel       <= `MDSD_MAP_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (awHeld && wHeld) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `MDSD_RESP_OKAY;
            // Status register is read-only: a write is answered OKAY and dropped
            if (awAddr == `MDSD_CLOCK_CONTROL_REG) begin
               if (wStrb[0])
                  stretch <= wData[`MDSD_STRETCH_MSB:0];
            end else if (awAddr == `MDSD_MAP_REG) begin
               if (wStrb[0])
                  mapSel <= wData[`MDSD_MAP_HI_BIT:`MDSD_MAP_LO_BIT];
            end else if (awAddr != `MDSD_STATUS_REG) begin
               s_axi_bresp <= `MDSD_RESP_DECERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read: one cycle after the address, held until taken
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge mclk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `MDSD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `MDSD_RESP_OKAY;
         if (s_axi_araddr == `MDSD_CLOCK_CONTROL_REG) begin
            s_axi_rdata <= {29'h0, stretch};
         end else if (s_axi_araddr == `MDSD_MAP_REG) begin
            s_axi_rdata <= {30'h0, mapSel};
         end else if (s_axi_araddr == `MDSD_STATUS_REG) begin
            s_axi_rdata <= {27'h0, !moveReady, 1'b0, lockStable};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MDSD_RESP_DECERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // mdsd_data_space
`default_nettype wire

// File: hw/mdsd_regs.vh
// Constants for the data-space move decoder and stretch unit.
// Assumes inclusion by mdsd_data_space.v only; holds definitions and notes only.
// Functional notes
// - With internal RAM enabled, 1kB SRAM sits at data addresses 0000h-03FFh.
// - With internal RAM enabled, addresses above 1kB go to the external bus.
// - With internal RAM disabled, every move from 0000h to FFFFh goes external.
// - Select 00 default all external; 01 SRAM low 1kB, rest external; 10 reserved.
// - Select 11: SRAM low 1kB; 0400h-FFFBh, FFFDh-FFFFh reserved, no bus access.
// - Select 11: read of FFFCh returns lock status in bits 2-0, 1 means programmed.
// - Select bits writable any time; new map applies to following moves.
// - Internal SRAM moves always take two machine cycles regardless of stretch.
// - Three-bit stretch field in clock control register bits 2-0, values 0-7.
// - External move length: stretch 0-3 gives 2-5, 4-7 gives 9-12 machine cycles.
// - Strobe width half a machine cycle at stretch 0, else stretch machine cycles.
// - Stretch 1 adds one crystal clock to both setup and hold versus stretch 0.
// - Stretch 4 and up: address latch strobe and address hold gain one machine cycle.
// - Stretch 4 and up: write data held one extra machine cycle after strobe.
// - Above stretch 4 setup and hold stay as at 4; only strobe width grows.
// - Stretch field resets to 1, giving three-cycle external moves.
// - Stretch affects data-space moves only, never program fetches.
// - Each external move uses the stretch value in force when it starts.
// - External moves drive low address/data on port 0, high address on port 2.
`ifndef MDSD_REGS_VH
`define MDSD_REGS_VH

// Register byte offsets
`define MDSD_CLOCK_CONTROL_REG 4'h0
`define MDSD_MAP_REG           4'h4
`define MDSD_STATUS_REG        4'h8

// Field positions and reset values
`define MDSD_STRETCH_MSB   2
`define MDSD_MAP_LO_BIT    0
`define MDSD_MAP_HI_BIT    1
`define MDSD_STRETCH_RESET 3'h1
`define MDSD_MAP_RESET     2'h0

// Address map
`define MDSD_SRAM_LAST   16'h03ff
`define MDSD_LOCK_ADDR   16'hfffc
`define MDSD_IDLE_DATA   8'h00

// Timing, in clocks of mclk (four clocks make one machine cycle)
`define MDSD_CLK_PER_MC  4
`define MDSD_INT_CLKS    6'h08
`define MDSD_SLOW_STEP   3'h4

// AXI responses
`define MDSD_RESP_OKAY   2'h0
`define MDSD_RESP_DECERR 2'h3

`endif

// File: tb/mdsd_ext_mem.sv
// Partner model: external byte memory on the multiplexed port 0/2 bus.
// Assumes the bench feeds p0Level to the design's p0In.
`timescale 1ns/100ps
`default_nettype none
module mdsd_ext_mem (
   input  wire logic       mclk,
   input  wire logic [7:0] p0Out,
   input  wire logic       p0Oe,
   input  wire logic [7:0] p2Out,
   input  wire logic       ale,
   input  wire logic       rdStrobe_n,
   input  wire logic       wrStrobe_n,
   output logic      [7:0] p0Level
);
   logic [7:0] mem [256];
   logic [15:0] addr;
   logic [7:0] wData, last;
   logic       wrPrev;
   logic [1:0] hold;
   // Low byte indexes the array; tests rely on 0410h aliasing to 0010h
   always @(posedge mclk) begin
      if (ale) addr <= {p2Out, p0Out};
      if (!wrStrobe_n) wData <= p0Out;
      if (wrStrobe_n && !wrPrev) mem[addr[7:0]] <= wData;
      wrPrev <= wrStrobe_n;
      hold <= !rdStrobe_n ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
      last <= p0Level;
   end
   // Released bus shows the inverse of its last value, never a stale copy
   always_comb begin
      if (p0Oe) p0Level = p0Out;
      else if (!rdStrobe_n || hold != 2'h0) p0Level = mem[addr[7:0]];
      else p0Level = ~last;
   end
endmodule // mdsd_ext_mem
`default_nettype wire

// File: tb/mdsd_data_space_asserts.sv
// Checker for the data-space move unit, bound to its top module.
// Assumes the master presents write address and data in one cycle.
`timescale 1ns/100ps
`default_nettype none
module mdsd_data_space_asserts (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        moveReq,
   input wire logic        moveWrite,
   input wire logic [15:0] moveAddr,
   input wire logic        moveReady,
   input wire logic        moveDone,
   input wire logic [7:0]  moveRdata,
   input wire logic [2:0]  securityLockFlags,
   input wire logic [7:0]  p0Out,
   input wire logic        p0Oe,
   input wire logic [7:0]  p2Out,
   input wire logic        p2Oe,
   input wire logic        ale,
   input wire logic        rdStrobe_n,
   input wire logic        wrStrobe_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [2:0] st, mvSt;
   logic [1:0] map;
   logic       busy, ext, rsvMap, rd;
   logic [15:0] mAddr;
   logic [7:0] cnt, expL, strbCnt, aleCnt;
   wire take = moveReq && moveReady;
   wire wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   wire extNow = !map[0] || (map == 2'h1 && moveAddr > 16'h03ff);
   // Shadow of stretch and map, plus move and pulse counters
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st <= 3'h1; map <= 2'h0; busy <= 1'b0; cnt <= 8'h00;
         strbCnt <= 8'h00; aleCnt <= 8'h00;
      end else begin
         if (wrHs && s_axi_awaddr == 4'h0) st <= s_axi_wdata[2:0];
         if (wrHs && s_axi_awaddr == 4'h4) map <= s_axi_wdata[1:0];
         if (take) begin
            busy <= 1'b1; cnt <= 8'h00; ext <= extNow; mvSt <= st; mAddr <= moveAddr;
            rd <= !moveWrite; rsvMap <= (map == 2'h3);
            expL <= extNow ? 8'(4 * (st < 3'h4 ? st + 2 : st + 5) - 1) : 8'h07;
         end else begin
            cnt <= cnt + 8'h01;
            if (moveDone) busy <= 1'b0;
         end
         strbCnt <= (rdStrobe_n && wrStrobe_n) ? 8'h00 : strbCnt + 8'h01;
         aleCnt <= ale ? aleCnt + 8'h01 : 8'h00;
      end
   end
   chk_move_len: assert property (moveDone |-> cnt == expL)
      else $error("move length wrong");
   chk_no_bus: assert property (busy && !ext |-> !ale && rdStrobe_n && wrStrobe_n)
      else $error("bus touched on internal move");
   chk_strobe_width: assert property ($rose(rdStrobe_n && wrStrobe_n) |->
      strbCnt == (mvSt == 3'h0 ? 8'h02 : {3'h0, mvSt, 2'h0}))
      else $error("strobe width wrong");
   chk_ale_width: assert property ($fell(ale) |-> aleCnt == (mvSt > 3'h3 ? 8'h06 : 8'h02))
      else $error("ale width wrong");
   chk_lock_read: assert property (moveDone && rd && rsvMap && mAddr == 16'hfffc |->
      moveRdata == {5'h00, securityLockFlags})
      else $error("lock status wrong");
   chk_rsv_read: assert property (moveDone && rd && rsvMap && mAddr > 16'h03ff &&
      mAddr != 16'hfffc |-> moveRdata == 8'h00)
      else $error("reserved read not zero");
   chk_p2_addr: assert property (busy && ext && cnt > 8'h01 && cnt + 8'h01 < expL |->
      p2Oe && p2Out == mAddr[15:8])
      else $error("high address missing");
   chk_p0_addr: assert property ($rose(ale) |-> p0Oe && p0Out == mAddr[7:0])
      else $error("low address missing");
   cover property (take && extNow && st > 3'h3);
   cover property (moveDone && rsvMap);
   cover property (take && !extNow);
endmodule // mdsd_data_space_asserts
bind mdsd_data_space mdsd_data_space_asserts uChk (.mclk(mclk), .rst_n(rst_n),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .moveReq(moveReq), .moveWrite(moveWrite), .moveAddr(moveAddr),
   .moveReady(moveReady), .moveDone(moveDone), .moveRdata(moveRdata),
   .securityLockFlags(securityLockFlags), .p0Out(p0Out), .p0Oe(p0Oe), .p2Out(p2Out),
   .p2Oe(p2Oe), .ale(ale), .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n));
`default_nettype wire

// File: tb/test_mdsd_data_space.sv
// Bench for the data-space move unit: AXI4-Lite master, CPU move driver.
// Assumes the external memory model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module test_mdsd_data_space;
   logic mclk, rst_n, awv, wv, bre, arv, rre, mReq, mWr;
   logic [3:0] awa, ara, wst;
   logic [31:0] wd, n;
   logic [15:0] mA;
   logic [7:0] mWd, rd;
   logic [2:0] lock;
   wire awr, wr, bv, arr, rv, mRdy, mDone, p0Oe, p2Oe, ale, rdS_n, wrS_n;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [7:0] mRd, p0Out, p2Out, p0In;
   int failCount = 0;
   int nChecks = 0;
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   mdsd_data_space uut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .moveReq(mReq),
      .moveWrite(mWr), .moveAddr(mA), .moveWdata(mWd), .moveReady(mRdy), .moveDone(mDone),
      .moveRdata(mRd), .securityLockFlags(lock), .p0In(p0In), .p0Out(p0Out), .p0Oe(p0Oe),
      .p2Out(p2Out), .p2Oe(p2Oe), .ale(ale), .rdStrobe_n(rdS_n), .wrStrobe_n(wrS_n));
   mdsd_ext_mem uMem (.mclk(mclk), .p0Out(p0Out), .p0Oe(p0Oe), .p2Out(p2Out), .ale(ale),
      .rdStrobe_n(rdS_n), .wrStrobe_n(wrS_n), .p0Level(p0In));
   task endSim;
      if (failCount == 0 && nChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Each channel released only at the edge that takes it
   task axw(input [3:0] a, input [31:0] d, input [1:0] er);
      logic ta, tw, tb; logic [1:0] r;
      @(posedge mclk); awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      ta = 0; tw = 0;
      do begin @(negedge mclk); tb = (awr === 1'b1); tw |= (wr === 1'b1);
         @(posedge mclk); if (tb) awv <= 1'b0; if (tw) wv <= 1'b0; ta |= tb;
      end while (!(ta && tw));
      do begin @(negedge mclk); tb = (bv === 1'b1); r = br; @(posedge mclk); end while (!tb);
      bre <= 1'b0;
      cmp({30'h0, r}, {30'h0, er});
   endtask
   task axr(input [3:0] a, input [31:0] ed, input [1:0] er);
      logic t; logic [31:0] d; logic [1:0] r;
      @(posedge mclk); ara <= a; arv <= 1'b1; rre <= 1'b1;
      do begin @(negedge mclk); t = (arr === 1'b1); @(posedge mclk); end while (!t);
      arv <= 1'b0;
      do begin @(negedge mclk); t = (rv === 1'b1); d = rdat; r = rr; @(posedge mclk); end while (!t);
      rre <= 1'b0;
      cmp({30'h0, r}, {30'h0, er});
      if (er == 2'h0) cmp(d, ed);
   endtask
   // n counts edges from the taking edge to the one that launches moveDone
   task mv(input w, input [15:0] a, input [7:0] d);
      logic t;
      @(posedge mclk); mReq <= 1'b1; mWr <= w; mA <= a; mWd <= d; n = 0;
      do begin @(negedge mclk); t = (mRdy === 1'b1); @(posedge mclk); end while (!t);
      mReq <= 1'b0;
      do begin @(negedge mclk); t = (mDone === 1'b1); rd = mRd; @(posedge mclk);
         if (!t) n++;
      end while (!t && n < 100);
   endtask
   function automatic logic [31:0] eLen(input logic [2:0] s);
      eLen = 4 * (s < 3'h4 ? s + 2 : s + 5) - 1;
   endfunction
   task tReset;
      axr(4'h0, 32'h1, 2'h0);
      axr(4'h4, 32'h0, 2'h0);
      axr(4'hc, 32'h0, 2'h3);
      mv(1'b1, 16'h2040, 8'h11); cmp(n, 32'd11);
   endtask
   task tStretch;
      for (logic [3:0] s = 0; s < 8; s++) begin
         axw(4'h0, {29'h0, s[2:0]}, 2'h0);
         mv(1'b1, {13'h0608, s[2:0]}, {5'h14, s[2:0]}); cmp(n, eLen(s[2:0]));
         mv(1'b0, {13'h0608, s[2:0]}, 8'h00); cmp({24'h0, rd}, {24'h14, s[2:0]});
         cmp(n, eLen(s[2:0]));
      end
   endtask
   task tMap;
      mv(1'b1, 16'h0010, 8'hc3); cmp(n, 32'd47);
      axw(4'h4, 32'h1, 2'h0);
      mv(1'b1, 16'h0010, 8'h5a); cmp(n, 32'd7);
      mv(1'b0, 16'h0010, 8'h00); cmp({24'h0, rd}, 32'h5a);
      mv(1'b0, 16'h0410, 8'h00); cmp({24'h0, rd}, 32'hc3);
      axw(4'h4, 32'h2, 2'h0);
      mv(1'b0, 16'h0010, 8'h00); cmp({24'h0, rd}, 32'hc3);
      axw(4'h4, 32'h3, 2'h0);
      mv(1'b0, 16'hfffc, 8'h00); cmp({24'h0, rd}, 32'h5);
      mv(1'b1, 16'h0510, 8'hff); cmp(n, 32'd7);
      mv(1'b0, 16'h0510, 8'h00); cmp({24'h0, rd}, 32'h0);
      axw(4'h8, 32'h0, 2'h0);
      axr(4'h8, 32'h5, 2'h0);
      lock <= 3'h2;
      repeat (6) @(posedge mclk);
      mv(1'b0, 16'hfffc, 8'h00); cmp({24'h0, rd}, 32'h2);
      axr(4'h8, 32'h2, 2'h0);
      axw(4'h4, 32'h0, 2'h0);
      mv(1'b0, 16'h0010, 8'h00); cmp({24'h0, rd}, 32'hc3);
   endtask
   initial begin
      rst_n = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; mReq = 0; mWr = 0;
      awa = 0; ara = 0; wst = 4'hf; wd = 0; mA = 0; mWd = 0; lock = 3'h5;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      tReset;
      tStretch;
      tMap;
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      tReset;
      endSim;
   end
   // Whole run is under a thousand cycles; 40000 means a hang
   initial begin
      #1000000;
      failCount++;
      endSim;
   end
endmodule // test_mdsd_data_space
`default_nettype wire
